// >>> design/sbc_safe_brake.sv
// one axis of safe brake control: input pair check, stop-one sequencing,
// brake engage/release on both lines, test pulses and muting override
// assumes all inputs are synchronous to ref_clk_i and one instance per axis
//
// Contract
// - dual channel mode compares both paired inputs
// - discrepancy over 100 ms: fail, warn, stop
// - stop-one selectable as monitor fault reaction
// - stop-one status drives two safe outputs
// - brake switched on both lines together
// - alternating 1 ms test pulses, 3 ms overall
// - immediate brake only from torque off
// - delayed trigger depends on dynamic braking
// - one or two brakes configurable
// - engage before or at torque off
// - fault report 0: release with torque off
// - fault report 1: release on axis enable
// - muting from fieldbus or safe input
// - muting allows override during active control
// - muting suppresses brake control active status
// - manual control rejected without muting when active
// - override automatic, force apply, force release
// - muted automatic follows standard brake demand
// - active status and 24V/0V brake state outputs
// - exactly one instance per axis
// - no dynamic braking: brake, delay, torque off; code does this only with engage_early set, else brake and torque off together
// - dynamic braking: brake and torque off together
`timescale 1ns/10ps

module sbc_safe_brake
	import sbc_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS,          // clock cycles per millisecond
	parameter int DISC_MS = DISC_LIMIT_MS,         // discrepancy limit in ms
	parameter int PULSE_GAP_MS = PULSE_PERIOD_MS   // test pulse spacing in ms
) (
	input wire logic ref_clk_i,                    // 125 MHz clock
	input wire logic rst_b_i,                      // synchronous reset, active low
	input wire logic [ADDR_W-1:0] addr_i,          // register byte address
	input wire logic [DATA_W-1:0] wdata_i,         // write data
	input wire logic wr_i,                         // write strobe
	input wire logic rd_i,                         // read strobe
	output logic [DATA_W-1:0] rdata_o,             // read data, cycle after rd_i
	input wire logic safe_in_a_i,                  // safe input pair, channel a
	input wire logic safe_in_b_i,                  // safe input pair, channel b
	input wire logic torque_off_req_i,             // direct torque off request
	input wire logic stop1_req_i,                  // stop-one request
	input wire logic monitor_fault_i,              // fault from other monitors
	input wire logic mute_in_i,                    // muting from mapped safe input
	input wire logic std_brake_release_i,          // standard brake demand, 1 releases
	input wire logic axis_enable_i,                // axis enable command
	output logic [NUM_BRAKES-1:0] brake_pos_o,     // positive brake lines, 1 = 24 V
	output logic [NUM_BRAKES-1:0] brake_neg_o,     // negative brake lines, 1 = switched
	output logic [NUM_BRAKES-1:0] brake_state_o,   // brake outputs at 24 V
	output logic torque_off_o,                     // power stage off
	output logic sbc_active_o,                     // brake control active status
	output logic stop1_active_o,                   // stop-one active status
	output logic [1:0] stop1_dout_o,               // dual channel safe output pair
	output logic io_warn_o                         // input failure warning
);

	// software visible registers
	sbc_ctrl_s ctrl_r;          // configuration
	logic [15:0] delay_r;       // brake delay time in ms
	logic [15:0] stop1_time_r;  // stop-one deceleration window in ms
	logic io_fail_r;            // sticky discrepancy failure
	logic reject_r;             // sticky manual override refusal

	// millisecond tick
	logic [31:0] ms_cnt_r;      // prescaler
	logic ms_tick;              // one cycle each ms

	// discrepancy timer
	logic [15:0] disc_cnt_r;    // ms with inputs apart
	logic disagree;             // inputs differ
	logic disc_expire;          // limit crossed this tick

	// stop-one sequencer
	sbc_s1_e s1_r;              // state
	logic [15:0] s1_cnt_r;      // deceleration ms
	logic stop1_trig;           // any stop-one cause
	logic s1_done;              // deceleration window over

	// brake sequencer
	sbc_seq_e seq_r;            // state
	sbc_seq_e seq_nxt;          // next state
	logic [15:0] dly_cnt_r;     // brake delay ms
	logic axis_en_d_r;          // axis enable, last cycle
	logic axis_en_rise;         // axis enable rising edge
	logic stop_req;             // any stop still requested

	// brake demand
	logic engaged;              // safety logic holds brakes on
	logic muting;               // muting in effect
	logic ovr_allowed;          // manual control permitted
	logic manual_req;           // manual override requested
	logic release_dmd;          // final release demand

	// test pulses
	sbc_tp_e tp_r;              // phase
	logic [15:0] tp_cnt_r;      // ms in phase
	logic tp_line_r;            // 0 pulses positive line, 1 negative
	logic pulse_pos;            // positive line held low now
	logic pulse_neg;            // negative line held low now

	// bus decode
	logic wr_ctrl;              // control write
	logic wr_delay;             // delay write
	logic wr_stop1;             // stop-one time write
	logic wr_status;            // status write, clears sticky bits
	sbc_stat_s stat;            // assembled status
	logic [DATA_W-1:0] rd_mux;  // read data selection
	logic [NUM_BRAKES-1:0] line_on;   // brake energised per brake
	logic [NUM_BRAKES-1:0] pos_nxt;   // positive line next value
	logic [NUM_BRAKES-1:0] neg_nxt;   // negative line next value

	// add one to a ms count and compare against a limit
	function automatic logic ms_reached(input logic [15:0] cnt, input logic [15:0] lim);
		ms_reached = (cnt + 16'h0001) >= lim;
	endfunction : ms_reached

	// register decode
	assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
	assign wr_delay = wr_i && (addr_i == OFS_DELAY);
	assign wr_stop1 = wr_i && (addr_i == OFS_STOP1);
	assign wr_status = wr_i && (addr_i == OFS_STATUS);

	// millisecond prescaler
	assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ms_cnt_r <= 32'h00000000;
		end else if (ms_tick) begin
			ms_cnt_r <= 32'h00000000;
		end else begin
			ms_cnt_r <= ms_cnt_r + 32'h00000001;
		end
	end

	assign disagree = ctrl_r.dual_channel && (safe_in_a_i != safe_in_b_i);
	assign disc_expire = disagree && ms_tick && ms_reached(disc_cnt_r, 16'(DISC_MS));

	// discrepancy timer, counts ms while the inputs differ
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			disc_cnt_r <= 16'h0000;
		end else if (!disagree) begin
			disc_cnt_r <= 16'h0000;
		end else if (ms_tick && !disc_expire) begin
			disc_cnt_r <= disc_cnt_r + 16'h0001;
		end
	end

	// sticky failure flags; a new event wins over a software clear
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			io_fail_r <= 1'b0;
			reject_r <= 1'b0;
		end else begin
			if (disc_expire) begin
				io_fail_r <= 1'b1;
			end else if (wr_status && wdata_i[7]) begin
				io_fail_r <= 1'b0;
			end
			if (manual_req && !ovr_allowed) begin
				reject_r <= 1'b1;
			end else if (wr_status && wdata_i[8]) begin
				reject_r <= 1'b0;
			end
		end
	end

	assign stop1_trig = stop1_req_i || (ctrl_r.fault_sel && monitor_fault_i) || io_fail_r;
	assign s1_done = (s1_r == S1_DONE);

	// stop-one: deceleration window, then asks for the brake sequence, delayed only with engage_early set and dyn_braking clear
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			s1_r <= S1_IDLE;
			s1_cnt_r <= 16'h0000;
		end else begin
			case (s1_r)
				S1_IDLE: begin
					s1_cnt_r <= 16'h0000;
					if (stop1_trig) begin
						s1_r <= S1_DECEL;
					end
				end
				S1_DECEL: begin
					// request withdrawn ends the instance
					if (!stop1_trig) begin
						s1_r <= S1_IDLE;
					end else if (ms_tick) begin
						if (ms_reached(s1_cnt_r, stop1_time_r)) begin
							s1_r <= S1_DONE;
						end
						s1_cnt_r <= s1_cnt_r + 16'h0001;
					end
				end
				S1_DONE: begin
					if (!stop1_trig) begin
						s1_r <= S1_IDLE;
					end
				end
				default: begin
					s1_r <= S1_IDLE;
				end
			endcase
		end
	end

	// brake sequencer
	assign stop_req = torque_off_req_i || s1_done;
	assign axis_en_rise = axis_enable_i && !axis_en_d_r;

	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			SQ_RUN: begin
				if (torque_off_req_i) begin
					seq_nxt = SQ_TORQUE_OFF;
				end else if (s1_done) begin
					if (ctrl_r.dyn_braking || !ctrl_r.engage_early) begin
						seq_nxt = SQ_TORQUE_OFF;
					end else begin
						seq_nxt = SQ_BRAKE_WAIT;
					end
				end
			end
			SQ_BRAKE_WAIT: begin
				if (torque_off_req_i) begin
					seq_nxt = SQ_TORQUE_OFF;
				end else if (!s1_done) begin
					seq_nxt = SQ_RUN;
				end else if (ms_tick && ms_reached(dly_cnt_r, delay_r)) begin
					seq_nxt = SQ_TORQUE_OFF;
				end
			end
			SQ_TORQUE_OFF: begin
				if (!stop_req) begin
					if (ctrl_r.fault_report) begin
						seq_nxt = SQ_HOLD;
					end else begin
						seq_nxt = SQ_RUN;
					end
				end
			end
			SQ_HOLD: begin
				if (stop_req) begin
					seq_nxt = SQ_TORQUE_OFF;
				end else if (axis_en_rise) begin
					seq_nxt = SQ_RUN;
				end
			end
			default: begin
				seq_nxt = SQ_RUN;
			end
		endcase
	end

	// sequencer state and brake delay counter
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			seq_r <= SQ_RUN;
			dly_cnt_r <= 16'h0000;
			axis_en_d_r <= 1'b0;
		end else begin
			seq_r <= seq_nxt;
			axis_en_d_r <= axis_enable_i;
			if (seq_r != SQ_BRAKE_WAIT) begin
				dly_cnt_r <= 16'h0000;
			end else if (ms_tick) begin
				dly_cnt_r <= dly_cnt_r + 16'h0001;
			end
		end
	end

	// brake demand and muting override; taken from the next state so that the
	// brake lines switch on the same edge as torque_off_o and sbc_active_o
	assign engaged = (seq_nxt != SQ_RUN);
	assign muting = ctrl_r.mute_bus || mute_in_i;
	assign ovr_allowed = muting || !engaged;
	assign manual_req = (ctrl_r.override != OVR_AUTO);

	always_comb begin
		if (ovr_allowed && (ctrl_r.override == OVR_APPLY)) begin
			release_dmd = 1'b0;
		end else if (ovr_allowed && (ctrl_r.override == OVR_RELEASE)) begin
			release_dmd = 1'b1;
		end else if (engaged && !muting) begin
			release_dmd = 1'b0;
		end else begin
			release_dmd = std_brake_release_i;
		end
	end

	assign line_on = ctrl_r.brake_en & {NUM_BRAKES{release_dmd}};

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			tp_r <= TP_WAIT;
			tp_cnt_r <= 16'h0000;
			tp_line_r <= 1'b0;
		end else if (line_on == '0) begin
			tp_r <= TP_WAIT;
			tp_cnt_r <= 16'h0000;
		end else if (ms_tick) begin
			tp_cnt_r <= tp_cnt_r + 16'h0001;
			case (tp_r)
				TP_WAIT: begin
					if (ms_reached(tp_cnt_r, 16'(PULSE_GAP_MS))) begin
						tp_r <= TP_LOW;
						tp_cnt_r <= 16'h0000;
					end
				end
				TP_LOW: begin
					if (ms_reached(tp_cnt_r, 16'(PULSE_LOW_MS))) begin
						tp_r <= TP_SETTLE;
						tp_cnt_r <= 16'h0000;
					end
				end
				TP_SETTLE: begin
					// slow edges: no next pulse until the whole pulse is over
					if (ms_reached(tp_cnt_r, 16'(PULSE_SETTLE_MS))) begin
						tp_r <= TP_WAIT;
						tp_cnt_r <= 16'h0000;
						tp_line_r <= !tp_line_r;
					end
				end
				default: begin
					tp_r <= TP_WAIT;
				end
			endcase
		end
	end

	assign pulse_pos = (tp_r == TP_LOW) && !tp_line_r;
	assign pulse_neg = (tp_r == TP_LOW) && tp_line_r;
	assign pos_nxt = line_on & {NUM_BRAKES{!pulse_pos}};
	assign neg_nxt = line_on & {NUM_BRAKES{!pulse_neg}};

	// status assembly
	assign stat.manual_reject = reject_r;
	assign stat.io_fail = io_fail_r;
	assign stat.muting = muting;
	assign stat.brake_24v = brake_state_o;
	assign stat.hold = (seq_r == SQ_HOLD);
	assign stat.sbc_active = sbc_active_o;
	assign stat.torque_off = torque_off_o;
	assign stat.stop1_active = stop1_active_o;

	// read selection; unmapped addresses read zero
	assign rd_mux = (addr_i == OFS_CTRL) ? DATA_W'(ctrl_r) :
		(addr_i == OFS_DELAY) ? DATA_W'(delay_r) :
		(addr_i == OFS_STOP1) ? DATA_W'(stop1_time_r) :
		(addr_i == OFS_STATUS) ? DATA_W'(stat) : '0;

	// configuration registers
	// one instance per axis
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ctrl_r <= sbc_ctrl_s'(CTRL_RST);
			delay_r <= DELAY_RST;
			stop1_time_r <= STOP1_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= sbc_ctrl_s'(wdata_i[10:0]);
			end
			if (wr_delay) begin
				delay_r <= wdata_i[15:0];
			end
			if (wr_stop1) begin
				stop1_time_r <= wdata_i[15:0];
			end
		end
	end

	// registered outputs
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rdata_o <= '0;
			brake_pos_o <= '0;
			brake_neg_o <= '0;
			brake_state_o <= '0;
			torque_off_o <= 1'b0;
			sbc_active_o <= 1'b0;
			stop1_active_o <= 1'b0;
			stop1_dout_o <= 2'h0;
			io_warn_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? rd_mux : '0;
			brake_pos_o <= pos_nxt;
			brake_neg_o <= neg_nxt;
			// brake state 24 V / 0 V
			brake_state_o <= line_on;
			torque_off_o <= (seq_nxt == SQ_TORQUE_OFF);
			sbc_active_o <= (seq_nxt != SQ_RUN) && !muting;
			stop1_active_o <= (s1_r != S1_IDLE);
			stop1_dout_o <= {2{ctrl_r.stop1_map && (s1_r != S1_IDLE)}};
			io_warn_o <= io_fail_r || disc_expire;
		end
	end

endmodule : sbc_safe_brake

// >>> design/sbc_pkg.sv
// package for the per-axis safe brake control block
// holds register offsets, field layout, reset values and timing figures
// assumes a 125 MHz reference clock and one block instance per axis
package sbc_pkg;
	// clock rate and the millisecond prescaler derived from it
	localparam int CLK_FREQ_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_FREQ_HZ / MS_PER_S;

	// input pair discrepancy limit, in ms
	localparam int DISC_LIMIT_MS = 100;
	// brake test pulse: low part and whole pulse including slow edges, in ms
	localparam int PULSE_LOW_MS = 1;
	localparam int PULSE_TOTAL_MS = 3;
	localparam int PULSE_SETTLE_MS = PULSE_TOTAL_MS - PULSE_LOW_MS;
	// spacing between test pulses while a brake is released, in ms
	localparam int PULSE_PERIOD_MS = 500;

	// register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DELAY = 8'h04;
	localparam logic [7:0] OFS_STOP1 = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// reset values: both brakes unused, dual channel input mode on
	localparam logic [10:0] CTRL_RST = 11'h020;
	// brake delay time in ms
	localparam logic [15:0] DELAY_RST = 16'h0064;
	// deceleration window of the stop-one instance in ms
	localparam logic [15:0] STOP1_RST = 16'h0064;

	// override setting codes
	localparam logic [1:0] OVR_AUTO = 2'h0;
	localparam logic [1:0] OVR_APPLY = 2'h1;
	localparam logic [1:0] OVR_RELEASE = 2'h2;

	// number of brakes per axis
	localparam int NUM_BRAKES = 2;

	// control register layout, lsb first from the bottom
	typedef struct packed {
		logic stop1_map;       // [10] map stop-one status on safe outputs
		logic [1:0] override;  // [9:8] brake override setting
		logic mute_bus;        // [7] muting requested over the fieldbus
		logic fault_sel;       // [6] monitor faults invoke stop-one
		logic dual_channel;    // [5] input pair checked as dual channel
		logic fault_report;    // [4] hold brakes until axis enable
		logic dyn_braking;     // [3] dynamic braking configured
		logic engage_early;    // [2] engage brakes before torque off
		logic [1:0] brake_en;  // [1:0] brake 2 / brake 1 used
	} sbc_ctrl_s;

	// status register layout
	typedef struct packed {
		logic manual_reject;   // [8] sticky: manual override refused
		logic io_fail;         // [7] sticky: input pair discrepancy
		logic muting;          // [6] muting in effect
		logic [1:0] brake_24v; // [5:4] brake outputs at 24 V
		logic hold;            // [3] brakes held after torque off
		logic sbc_active;      // [2] brake control active, after muting
		logic torque_off;      // [1] torque off enforced
		logic stop1_active;    // [0] stop-one instance active
	} sbc_stat_s;

	// test pulse phases
	typedef enum logic [1:0] {
		TP_WAIT,
		TP_LOW,
		TP_SETTLE
	} sbc_tp_e;

	// brake sequence states
	typedef enum logic [1:0] {
		SQ_RUN,
		SQ_BRAKE_WAIT,
		SQ_TORQUE_OFF,
		SQ_HOLD
	} sbc_seq_e;

	// stop-one states
	typedef enum logic [1:0] {
		S1_IDLE,
		S1_DECEL,
		S1_DONE
	} sbc_s1_e;
endpackage : sbc_pkg

// >>> bench/sbc_brake_model.sv
// behavioural pair of holding brakes on the two switched lines of each output
// assumes lines come from the safe brake block, 1 = energised
`timescale 1ns/10ps
module sbc_brake_model #(
	parameter int HOLD_CYC = 15 // cycles without current before a brake drops in
) (
	input wire logic ref_clk_i, // clock
	input wire logic [1:0] pos_i, // positive lines
	input wire logic [1:0] neg_i, // negative lines
	output logic [1:0] applied_o // 1 = brake holding
);
	for (genvar i = 0; i < 2; i++) begin : g_brk
		int off_cnt = 100; // cycles without coil current
		// coil needs both lines
		// current flows only with both lines on; slow decay rides out a test pulse
		always_ff @(posedge ref_clk_i) begin
			off_cnt <= (pos_i[i] && neg_i[i]) ? 0 : off_cnt + 1;
		end
		assign applied_o[i] = off_cnt > HOLD_CYC;
	end
endmodule : sbc_brake_model

// >>> bench/sbc_safe_brake_asserts.sv
// port checker for the safe brake block
// assumes the bind below and the parameters of the bound instance
`timescale 1ns/10ps
module sbc_safe_brake_asserts
	import sbc_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS, // cycles per ms
	parameter int DISC_MS = DISC_LIMIT_MS, // discrepancy limit in ms
	parameter int PULSE_GAP_MS = PULSE_PERIOD_MS // pulse spacing in ms
) (
	input wire logic ref_clk_i, // clock
	input wire logic rst_b_i, // reset
	input wire logic [ADDR_W-1:0] addr_i, // address
	input wire logic [DATA_W-1:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [DATA_W-1:0] rdata_o, // read data
	input wire logic safe_in_a_i, // pair a
	input wire logic safe_in_b_i, // pair b
	input wire logic torque_off_req_i, // torque off request
	input wire logic stop1_req_i, // stop-one request
	input wire logic monitor_fault_i, // monitor fault
	input wire logic mute_in_i, // muting input
	input wire logic std_brake_release_i, // standard demand
	input wire logic axis_enable_i, // axis enable
	input wire logic [NUM_BRAKES-1:0] brake_pos_o, // pos lines
	input wire logic [NUM_BRAKES-1:0] brake_neg_o, // neg lines
	input wire logic [NUM_BRAKES-1:0] brake_state_o, // 24 V state
	input wire logic torque_off_o, // torque off
	input wire logic sbc_active_o, // active status
	input wire logic stop1_active_o, // stop-one active
	input wire logic [1:0] stop1_dout_o, // safe output pair
	input wire logic io_warn_o // input warning
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	int lo_cnt; // cycles of the running pos line pulse
	int dis_cnt; // cycles the input pair disagrees
	// count pulse low time and disagreement time
	always_ff @(posedge ref_clk_i) begin
		lo_cnt <= (brake_state_o[0] && !brake_pos_o[0]) ? lo_cnt + 1 : 0;
		dis_cnt <= (safe_in_a_i != safe_in_b_i) ? dis_cnt + 1 : 0;
	end
	a_torque_now: assert property (rst_b_i && $past(rst_b_i) && torque_off_req_i |=> torque_off_o)
		else $error("torque off did not follow its request");
	a_lines_follow: assert property (((brake_pos_o | brake_neg_o) & ~brake_state_o) == 2'h0)
		else $error("brake line on while brake output at 0 V");
	a_pulse_side: assert property (brake_state_o[0] |-> brake_pos_o[0] || brake_neg_o[0])
		else $error("both lines pulsed at once");
	a_pulse_len: assert property ($rose(brake_pos_o[0]) && $past(brake_state_o[0]) |-> lo_cnt == MS_CYCLES)
		else $error("test pulse low time wrong");
	a_dout_pair: assert property (stop1_dout_o[0] |-> stop1_dout_o[1] && (stop1_active_o || $past(stop1_active_o)))
		else $error("stop-one output pair mismatch");
	a_warn_stop: assert property ($rose(io_warn_o) |-> ##[0:3] stop1_active_o)
		else $error("input failure did not start stop-one");
	a_disc_time: assert property ($rose(io_warn_o) |-> dis_cnt >= (DISC_MS - 1) * MS_CYCLES
		&& dis_cnt <= DISC_MS * MS_CYCLES + 3)
		else $error("discrepancy limit time wrong");
	a_warn_sticky: assert property (io_warn_o && !$past(wr_i && addr_i == OFS_STATUS && wdata_i[7])
		&& !(wr_i && addr_i == OFS_STATUS && wdata_i[7]) |=> io_warn_o)
		else $error("input warning dropped without clear");
	a_mute_quiet: assert property (mute_in_i && $past(mute_in_i) && $past(mute_in_i, 2) |-> !sbc_active_o)
		else $error("active status shown while muted");
	c_torque: cover property ($rose(torque_off_o));
	c_warn: cover property ($rose(io_warn_o));
	c_pulse: cover property ($rose(brake_pos_o[0]) && brake_state_o[0]);
endmodule : sbc_safe_brake_asserts

bind sbc_safe_brake sbc_safe_brake_asserts #(.MS_CYCLES(MS_CYCLES), .DISC_MS(DISC_MS),
	.PULSE_GAP_MS(PULSE_GAP_MS)) chk_u (.ref_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .safe_in_a_i, .safe_in_b_i, .torque_off_req_i, .stop1_req_i, .monitor_fault_i,
	.mute_in_i, .std_brake_release_i, .axis_enable_i, .brake_pos_o, .brake_neg_o, .brake_state_o,
	.torque_off_o, .sbc_active_o, .stop1_active_o, .stop1_dout_o, .io_warn_o);

// >>> bench/sbc_safe_brake_test.sv
// self-checking bench for one axis of safe brake control
// assumes short ms prescaler and limits passed as parameters
`timescale 1ns/10ps
module sbc_safe_brake_test
	import sbc_pkg::*;
;
	localparam int MSC = 10; // cycles per ms in this run
	typedef struct {logic [31:0] c; logic m; logic s; logic [2:0] e;} sbc_row_s;
	// rows with torque off held, all but the last muted: ctrl, mute input, demand, {state, active}
	sbc_row_s rows [7] = '{'{32'h123, 1, 1, 3'h0}, '{32'h223, 1, 0, 3'h6}, '{32'h023, 1, 1, 3'h6},
		'{32'h023, 1, 0, 3'h0}, '{32'h0A3, 0, 1, 3'h6}, '{32'h221, 1, 1, 3'h2}, '{32'h023, 0, 1, 3'h1}};
	logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}; // register addresses
	logic [31:0] re [5] = '{32'h20, 32'h64, 32'h64, 32'h0, 32'h0}; // reset values
	logic ref_clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0; // clock, reset, strobes
	logic [7:0] addr_i = 8'h00; // address
	logic [31:0] wdata_i = 32'h0, rdata_o; // bus data
	logic safe_in_a_i = 0, safe_in_b_i = 0, torque_off_req_i = 0, stop1_req_i = 0; // commands
	logic monitor_fault_i = 0, mute_in_i = 0, std_brake_release_i = 1, axis_enable_i = 0; // commands
	logic [1:0] brake_pos_o, brake_neg_o, brake_state_o, stop1_dout_o, applied; // brake side
	logic torque_off_o, sbc_active_o, stop1_active_o, io_warn_o; // status
	int error_cnt = 0, n_checks = 0; // counters
	always #4 ref_clk_i = ~ref_clk_i;
	sbc_safe_brake #(.MS_CYCLES(MSC), .DISC_MS(4), .PULSE_GAP_MS(5)) dut_u (.ref_clk_i, .rst_b_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .safe_in_a_i, .safe_in_b_i, .torque_off_req_i,
		.stop1_req_i, .monitor_fault_i, .mute_in_i, .std_brake_release_i, .axis_enable_i,
		.brake_pos_o, .brake_neg_o, .brake_state_o, .torque_off_o, .sbc_active_o, .stop1_active_o,
		.stop1_dout_o, .io_warn_o);
	sbc_brake_model bm_u (.ref_clk_i, .pos_i(brake_pos_o), .neg_i(brake_neg_o), .applied_o(applied));
	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// wait cycles, then let the edge settle
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : wt
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	// one-cycle register read, data in the next cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	// verdict
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// watchdog against a hang
	initial begin
		#(8 * 20000);
		error_cnt++;
		wrap_up();
	end
	// main sequence
	initial begin
		logic [31:0] d;
		int i;
		wt(10);
		@(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		torque_off_req_i <= 1'b1;
		foreach (rows[k]) begin
			wr(OFS_CTRL, rows[k].c);
			@(posedge ref_clk_i);
			mute_in_i <= rows[k].m;
			std_brake_release_i <= rows[k].s;
			wt(5);
			chk("mute row", 32'({brake_state_o, sbc_active_o}), 32'(rows[k].e));
		end
		// override refused without muting
		wr(OFS_CTRL, 32'h223);
		rd(OFS_STATUS, d);
		chk("reject", {d[8], 29'h0, brake_state_o}, 32'h8000_0000);
		wr(OFS_CTRL, 32'h023);
		wr(OFS_STATUS, 32'h100);
		rd(OFS_STATUS, d);
		chk("reject clr", 32'(d[8]), 32'h0);
		// immediate torque off, release together
		@(posedge ref_clk_i);
		std_brake_release_i <= 1'b1;
		torque_off_req_i <= 1'b0;
		wt(4);
		chk("run", 32'({torque_off_o, brake_state_o, applied}), 32'hC);
		@(posedge ref_clk_i);
		torque_off_req_i <= 1'b1;
		wt(1);
		chk("sto", 32'({torque_off_o, sbc_active_o, brake_state_o}), 32'hC);
		wt(20);
		chk("applied", 32'(applied), 32'h3);
		// held after torque off until axis enable
		wr(OFS_CTRL, 32'h033);
		@(posedge ref_clk_i);
		torque_off_req_i <= 1'b0;
		wt(4);
		chk("hold", 32'({torque_off_o, brake_state_o}), 32'h0);
		@(posedge ref_clk_i);
		axis_enable_i <= 1'b1;
		wt(4);
		chk("enable", 32'(brake_state_o), 32'h3);
		// monitor fault stop-one, brakes before torque off
		wr(OFS_CTRL, 32'h467);
		wr(OFS_DELAY, 32'h2);
		wr(OFS_STOP1, 32'h2);
		@(posedge ref_clk_i);
		monitor_fault_i <= 1'b1;
		wt(3);
		chk("stop1", 32'({stop1_active_o, stop1_dout_o}), 32'h7);
		for (i = 0; i < 100 && brake_state_o !== 2'h0; i++) wt(1);
		chk("early", 32'(torque_off_o), 32'h0);
		for (i = 0; i < 100 && torque_off_o !== 1'b1; i++) wt(1);
		chk("delay", 32'(i >= MSC - 1 && i <= 2 * MSC + 1), 32'h1);
		@(posedge ref_clk_i);
		monitor_fault_i <= 1'b0;
		wt(4);
		// dynamic braking: brakes and torque off together
		wr(OFS_CTRL, 32'h02F);
		@(posedge ref_clk_i);
		stop1_req_i <= 1'b1;
		for (i = 0; i < 100 && brake_state_o !== 2'h0; i++) wt(1);
		chk("together", 32'(torque_off_o), 32'h1);
		@(posedge ref_clk_i);
		stop1_req_i <= 1'b0;
		wr(OFS_CTRL, 32'h023);
		// short disagreements restart the timer, a long one fails
		@(posedge ref_clk_i);
		safe_in_a_i <= 1'b1;
		wt(25);
		@(posedge ref_clk_i);
		safe_in_a_i <= 1'b0;
		wt(2);
		@(posedge ref_clk_i);
		safe_in_a_i <= 1'b1;
		wt(25);
		chk("warn early", 32'(io_warn_o), 32'h0);
		wt(30);
		rd(OFS_STATUS, d);
		chk("io fail", 32'({io_warn_o, stop1_active_o, d[7]}), 32'h7);
		@(posedge ref_clk_i);
		safe_in_a_i <= 1'b0;
		wr(OFS_STATUS, 32'h80);
		wt(60);
		// test pulses alternate between the lines
		for (i = 0; i < 200 && brake_pos_o[0] !== 1'b0; i++) wt(1);
		chk("pos pulse", 32'({brake_pos_o[0], brake_neg_o[0], brake_state_o[0]}), 32'h3);
		for (i = 0; i < 200 && brake_neg_o[0] !== 1'b0; i++) wt(1);
		chk("neg pulse", 32'({brake_pos_o[0], brake_neg_o[0], applied[0]}), 32'h4);
		// mid-run reset, then reset values and an unmapped place
		@(posedge ref_clk_i);
		rst_b_i <= 1'b0;
		wt(2);
		chk("rst out", 32'({brake_state_o, torque_off_o, io_warn_o}), 32'h0);
		@(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		wr(8'h10, 32'hFFFF_FFFF);
		for (i = 0; i < 5; i++) begin
			rd(ra[i], d);
			chk("reg", d, re[i]);
		end
		wrap_up();
	end
endmodule : sbc_safe_brake_test
